// *** ccsr_top.sv ***
`timescale 1ns/10ps
module ccsr_top import ccsr_pkg::*; #(
  parameter int ADDR_W = 12
) (
  // Clock and reset
  input wire logic MCLK_IN,
  input wire logic ARST_N_IN,
  // Core operation port
  input wire logic CORE_OP_VALID_IN,
  input wire logic [3:0] CORE_OP_IN,
  input wire logic [7:0] CORE_A_IN,
  input wire logic [7:0] CORE_W_IN,
  input wire logic [2:0] CORE_BIT_IN,
  input wire logic CORE_DEST_F_IN,
  input wire logic [8:0] CORE_ADDR_IN,
  input wire logic CORE_RD_IN,
  input wire logic [8:0] CORE_RADDR_IN,
  // Reset, sleep, watchdog-clear and counter-load events
  input wire logic MASTER_RESET_PIN_IN,
  input wire logic WDT_RESET_IN,
  input wire logic SLEEP_IN,
  input wire logic WDT_CLEAR_IN,
  input wire logic PC_LOAD_IN,
  // Core outputs
  output logic [7:0] STATUS_OUT,
  output logic [7:0] RESULT_OUT,
  output logic [7:0] CORE_RDATA_OUT,
  output logic [4:0] PC_UPPER_OUT,
  // AXI4-Lite slave
  input wire logic [ADDR_W-1:0] S_AXI_AWADDR_IN,
  input wire logic S_AXI_AWVALID_IN,
  output logic S_AXI_AWREADY_OUT,
  input wire logic [31:0] S_AXI_WDATA_IN,
  input wire logic [3:0] S_AXI_WSTRB_IN,
  input wire logic S_AXI_WVALID_IN,
  output logic S_AXI_WREADY_OUT,
  output logic [1:0] S_AXI_BRESP_OUT,
  output logic S_AXI_BVALID_OUT,
  input wire logic S_AXI_BREADY_IN,
  input wire logic [ADDR_W-1:0] S_AXI_ARADDR_IN,
  input wire logic S_AXI_ARVALID_IN,
  output logic S_AXI_ARREADY_OUT,
  output logic [31:0] S_AXI_RDATA_OUT,
  output logic [1:0] S_AXI_RRESP_OUT,
  output logic S_AXI_RVALID_OUT,
  input wire logic S_AXI_RREADY_IN
);

  // Elaboration check
  if (ADDR_W < 12 || ADDR_W > 32) begin : g_bad_addr_w
    $error("ADDR_W must lie between 12 and 32");
  end

  // Status write with protected reset flags and ALU flag override
  function automatic logic [7:0] st_merge(input logic [7:0] old,
      input logic [7:0] data, input logic [2:0] fm, input logic [2:0] fl);
    logic [7:0] r;
    r = data;
    r[BIT_TO] = old[BIT_TO];
    r[BIT_PD] = old[BIT_PD];
    // Flag ops block the data write to all three flags
    r[BIT_Z:BIT_C] = (fm == 3'h0) ? data[BIT_Z:BIT_C] :
                     (fm & fl) | (~fm & old[BIT_Z:BIT_C]);
    return r;
  endfunction

  logic [7:0] status_q, status_d, result_q, rdata_q, rdata_d;
  logic [4:0] hold_q, hold_d, pcup_q, pcup_d;
  logic awready_q, wready_q, bvalid_q, arready_q, rvalid_q;
  logic aw_have_q, w_have_q, wstrb0_q;
  logic [ADDR_W-1:0] awaddr_q;
  logic [7:0] wdata_q;
  logic [31:0] axi_rdata_q;
  logic [7:0] alu_res;
  logic [2:0] alu_fm, alu_fl;

  // Bank-independent decode of the core destination and read address
  wire op_do = CORE_OP_VALID_IN;
  wire dest_st = op_do && CORE_DEST_F_IN &&
                 (CORE_ADDR_IN[6:0] == OFF_STATUS);
  wire dest_hold = op_do && CORE_DEST_F_IN &&
                   (CORE_ADDR_IN[6:0] == OFF_PC_HOLD);
  wire rd_st = (CORE_RADDR_IN[6:0] == OFF_STATUS);
  wire rd_hold = (CORE_RADDR_IN[6:0] == OFF_PC_HOLD);
  wire [7:0] alu_a = (CORE_ADDR_IN[6:0] == OFF_STATUS) ? status_q :
                     (CORE_ADDR_IN[6:0] == OFF_PC_HOLD) ? {3'h0, hold_q} :
                     CORE_A_IN;

  // Flag and result unit
  ccsr_alu u_alu (
    .op_in(CORE_OP_IN),
    .a_in(alu_a),
    .w_in(CORE_W_IN),
    .bit_in(CORE_BIT_IN),
    .carry_in(status_q[BIT_C]),
    .res_out(alu_res),
    .fmask_out(alu_fm),
    .flags_out(alu_fl)
  );

  // Write channel handshake and commit
  wire aw_take = S_AXI_AWVALID_IN && awready_q;
  wire w_take = S_AXI_WVALID_IN && wready_q;
  wire aw_have = aw_have_q || aw_take;
  wire w_have = w_have_q || w_take;
  wire do_wr = aw_have && w_have;
  wire [ADDR_W-1:0] wr_addr = aw_take ? S_AXI_AWADDR_IN : awaddr_q;
  wire [7:0] wr_data = w_take ? S_AXI_WDATA_IN[7:0] : wdata_q;
  wire wr_lane0 = w_take ? S_AXI_WSTRB_IN[0] : wstrb0_q;
  wire axi_wr_st = do_wr && wr_lane0 &&
                   (wr_addr == ADDR_W'(AXI_STATUS));
  wire axi_wr_hold = do_wr && wr_lane0 &&
                     (wr_addr == ADDR_W'(AXI_PC_HOLD));
  wire bvalid_d = do_wr || (bvalid_q && !S_AXI_BREADY_IN);
  wire aw_have_d = aw_have && !do_wr;
  wire w_have_d = w_have && !do_wr;

  // Read channel handshake and decode
  wire ar_take = S_AXI_ARVALID_IN && arready_q;
  wire rvalid_d = ar_take || (rvalid_q && !S_AXI_RREADY_IN);
  wire [31:0] axi_rsel =
    (S_AXI_ARADDR_IN == ADDR_W'(AXI_STATUS)) ? {24'h000000, status_q} :
    (S_AXI_ARADDR_IN == ADDR_W'(AXI_PC_HOLD)) ? {27'h0000000, hold_q} :
    32'h00000000;

  // Status next value: events, then core op, then software
  wire ev_rst = MASTER_RESET_PIN_IN || WDT_RESET_IN;
  wire [7:0] st_op = !op_do ? status_q :
    dest_st ? st_merge(status_q, alu_res, alu_fm, alu_fl) :
    {status_q[7:3], (alu_fm & alu_fl) | (~alu_fm & status_q[2:0])};
  wire [7:0] st_sw = (axi_wr_st && !op_do) ?
    st_merge(status_q, wr_data, 3'h0, 3'h0) : st_op;
  assign status_d[BIT_IRP:BIT_RP0] = ev_rst ? 3'h0 :
                                     st_sw[BIT_IRP:BIT_RP0];
  assign status_d[BIT_TO] = WDT_RESET_IN ? 1'b0 :
    (SLEEP_IN || WDT_CLEAR_IN) ? 1'b1 : status_q[BIT_TO];
  assign status_d[BIT_PD] = SLEEP_IN ? 1'b0 :
    WDT_CLEAR_IN ? 1'b1 : status_q[BIT_PD];
  assign status_d[BIT_Z:BIT_C] = ev_rst ? status_q[BIT_Z:BIT_C] :
                                 st_sw[BIT_Z:BIT_C];

  // Holding register, counter upper bits and core read data
  assign hold_d = ev_rst ? PC_HOLD_RST :
    dest_hold ? alu_res[4:0] :
    (axi_wr_hold && !op_do) ? wr_data[4:0] : hold_q;
  assign pcup_d = ev_rst ? PC_HOLD_RST :
    PC_LOAD_IN ? hold_q : pcup_q;
  assign rdata_d = !CORE_RD_IN ? rdata_q :
    rd_st ? status_q : rd_hold ? {3'h0, hold_q} : 8'h00;

  // Core-side state
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      status_q <= STATUS_POR;
      hold_q <= PC_HOLD_RST;
      pcup_q <= PC_HOLD_RST;
      result_q <= 8'h00;
      rdata_q <= 8'h00;
    end else begin
      status_q <= status_d;
      hold_q <= hold_d;
      pcup_q <= pcup_d;
      result_q <= op_do ? alu_res : result_q;
      rdata_q <= rdata_d;
    end
  end

  // Bus-side state
  always_ff @(posedge MCLK_IN or negedge ARST_N_IN) begin
    if (!ARST_N_IN) begin
      {aw_have_q, w_have_q, bvalid_q, rvalid_q} <= 4'h0;
      {awready_q, wready_q, arready_q} <= 3'h7;
      awaddr_q <= '0;
      wdata_q <= 8'h00;
      wstrb0_q <= 1'b0;
      axi_rdata_q <= 32'h00000000;
    end else begin
      aw_have_q <= aw_have_d;
      w_have_q <= w_have_d;
      bvalid_q <= bvalid_d;
      awready_q <= !aw_have_d && !bvalid_d;
      wready_q <= !w_have_d && !bvalid_d;
      rvalid_q <= rvalid_d;
      arready_q <= !rvalid_d;
      if (aw_take) awaddr_q <= S_AXI_AWADDR_IN;
      if (w_take) wdata_q <= S_AXI_WDATA_IN[7:0];
      if (w_take) wstrb0_q <= S_AXI_WSTRB_IN[0];
      if (ar_take) axi_rdata_q <= axi_rsel;
    end
  end

  // Outputs
  assign STATUS_OUT = status_q;
  assign RESULT_OUT = result_q;
  assign CORE_RDATA_OUT = rdata_q;
  assign PC_UPPER_OUT = pcup_q;
  assign S_AXI_AWREADY_OUT = awready_q;
  assign S_AXI_WREADY_OUT = wready_q;
  assign S_AXI_BRESP_OUT = AXI_RESP_OKAY;
  assign S_AXI_BVALID_OUT = bvalid_q;
  assign S_AXI_ARREADY_OUT = arready_q;
  assign S_AXI_RDATA_OUT = axi_rdata_q;
  assign S_AXI_RRESP_OUT = AXI_RESP_OKAY;
  assign S_AXI_RVALID_OUT = rvalid_q;

  // Checks
  default clocking cb @(posedge MCLK_IN); endclocking
  default disable iff (!ARST_N_IN);
  wire ev_none = !(ev_rst || SLEEP_IN || WDT_CLEAR_IN);

  a_store_status: assert property (
    dest_st && CORE_OP_IN == OP_STORE && ev_none
    |=> status_q[7:5] == $past(CORE_W_IN[7:5])
        && status_q[2:0] == $past(CORE_W_IN[2:0]))
    else $error("store to status not applied");
  a_flags_from_alu: assert property (
    dest_st && CORE_OP_IN == OP_ADD && ev_none
    |=> status_q[2:0] == $past(alu_fl))
    else $error("flags not taken from ALU");
  a_reset_flags_ro: assert property (
    ev_none |=> $stable(status_q[4:3]))
    else $error("reset flags changed by a write");
  a_clear_pattern: assert property (
    dest_st && CORE_OP_IN == OP_CLEAR && ev_none
    |=> status_q[7:5] == 3'h0 && status_q[2] && $stable(status_q[4:3])
        && $stable(status_q[1:0]))
    else $error("register-zero on status wrong");
  a_sub_borrow: assert property (
    op_do && CORE_OP_IN == OP_SUB && !dest_st && ev_none
    |=> status_q[BIT_C] == ($past(alu_a) >= $past(CORE_W_IN)))
    else $error("subtract carry not inverted borrow");
  a_rotate_carry: assert property (
    op_do && CORE_OP_IN == OP_RRF && !dest_st && ev_none
    |=> status_q[BIT_C] == $past(alu_a[0]))
    else $error("rotate carry wrong");
  a_pc_upper_load: assert property (
    PC_LOAD_IN && !ev_rst |=> PC_UPPER_OUT == $past(hold_q))
    else $error("upper counter not loaded from holding");
  a_bank_mirror: assert property (
    CORE_RD_IN && rd_st |=> CORE_RDATA_OUT == $past(status_q))
    else $error("status read differs by bank");
  a_unimpl_zero: assert property (
    CORE_RD_IN && !rd_st && !rd_hold |=> CORE_RDATA_OUT == 8'h00)
    else $error("unimplemented location not zero");
  a_nonpor_reset: assert property (
    MASTER_RESET_PIN_IN |=> status_q[7:5] == 3'h0 && hold_q == 5'h00
    && PC_UPPER_OUT == 5'h00)
    else $error("pin reset values wrong");
  a_bresp_hold: assert property (
    bvalid_q && !S_AXI_BREADY_IN |=> bvalid_q[*2] or (bvalid_q ##1 !bvalid_q))
    else $error("write response dropped");

  c_clear_status: cover property (dest_st && CORE_OP_IN == OP_CLEAR);
  c_sub_borrow: cover property (op_do && CORE_OP_IN == OP_SUB
                                ##1 !status_q[BIT_C]);
  c_axi_write: cover property (axi_wr_hold ##[1:4] PC_LOAD_IN);
  c_wdt_reset: cover property (WDT_RESET_IN ##1 !status_q[BIT_TO]);

endmodule

// *** ccsr_pkg.sv ***
package ccsr_pkg;

  // Status bit positions, 7 down to 0
  localparam int BIT_C = 0;
  localparam int BIT_DC = 1;
  localparam int BIT_Z = 2;
  localparam int BIT_PD = 3;
  localparam int BIT_TO = 4;
  localparam int BIT_RP0 = 5;
  localparam int BIT_RP1 = 6;
  localparam int BIT_IRP = 7;

  // Values after power-up reset
  localparam logic [7:0] STATUS_POR = 8'h18;
  localparam logic [4:0] PC_HOLD_RST = 5'h00;

  // Core-side file offsets within a bank
  localparam logic [6:0] OFF_STATUS = 7'h03;
  localparam logic [6:0] OFF_PC_HOLD = 7'h0A;

  // Software byte offsets and OKAY response code on the register bus
  localparam logic [11:0] AXI_STATUS = 12'h000;
  localparam logic [11:0] AXI_PC_HOLD = 12'h004;
  localparam logic [1:0] AXI_RESP_OKAY = 2'h0;

  // Core operation codes
  localparam logic [3:0] OP_STORE = 4'h0;
  localparam logic [3:0] OP_CLEAR = 4'h1;
  localparam logic [3:0] OP_ADD = 4'h2;
  localparam logic [3:0] OP_SUB = 4'h3;
  localparam logic [3:0] OP_RRF = 4'h4;
  localparam logic [3:0] OP_RLF = 4'h5;
  localparam logic [3:0] OP_BCLR = 4'h6;
  localparam logic [3:0] OP_BSET = 4'h7;
  localparam logic [3:0] OP_SWAP = 4'h8;

endpackage

// *** ccsr_alu.sv ***
`timescale 1ns/10ps
module ccsr_alu import ccsr_pkg::*; (
  // Operation
  input wire logic [3:0] op_in,
  input wire logic [7:0] a_in,
  input wire logic [7:0] w_in,
  input wire logic [2:0] bit_in,
  input wire logic carry_in,
  // Result and flags as {zero, nibble wrap, carry}
  output logic [7:0] res_out,
  output logic [2:0] fmask_out,
  output logic [2:0] flags_out
);

  // Subtraction adds the two's complement of w
  wire is_sub = (op_in == OP_SUB);
  wire [7:0] w_eff = is_sub ? ~w_in : w_in;
  wire [8:0] sum = {1'b0, a_in} + {1'b0, w_eff} + {8'h00, is_sub};
  wire [4:0] nsum = {1'b0, a_in[3:0]} + {1'b0, w_eff[3:0]} + {4'h0, is_sub};
  wire [7:0] bmask = 8'h01 << bit_in;
  logic carry_bit;

  // Result, carry and affected-flag selection
  always_comb begin
    res_out = a_in;
    carry_bit = 1'b0;
    fmask_out = 3'h0;
    unique case (op_in)
      OP_STORE: res_out = w_in;
      OP_CLEAR: begin
        res_out = 8'h00;
        fmask_out = 3'h4;
      end
      OP_ADD, OP_SUB: begin
        res_out = sum[7:0];
        carry_bit = sum[8];
        fmask_out = 3'h7;
      end
      OP_RRF: begin
        res_out = {carry_in, a_in[7:1]};
        carry_bit = a_in[0];
        fmask_out = 3'h1;
      end
      OP_RLF: begin
        res_out = {a_in[6:0], carry_in};
        carry_bit = a_in[7];
        fmask_out = 3'h1;
      end
      OP_BCLR: res_out = a_in & ~bmask;
      OP_BSET: res_out = a_in | bmask;
      OP_SWAP: res_out = {a_in[3:0], a_in[7:4]};
      default: res_out = a_in;
    endcase
  end

  // Nibble wrap inverts to borrow meaning on subtraction
  assign flags_out = {(res_out == 8'h00), nsum[4], carry_bit};

endmodule

// *** tb.sv ***
`timescale 1ns/10ps
module tb import ccsr_pkg::*;;
  logic clk, rst_n, op_v, rd, awv, wv, bready, arv, rready;
  logic [3:0] op;
  logic [7:0] a, cw, status, result, rdata_c;
  logic [2:0] bsel;
  logic [8:0] addr, raddr;
  logic [4:0] ev;
  logic [4:0] pcu;
  logic [11:0] awaddr, araddr;
  logic [31:0] wdata, rdata;
  logic awrdy, wrdy, bvalid, arrdy, rvalid;
  logic dest;
  logic [1:0] bresp, rresp;
  int fails, samples_checked;

  // Design under test, events as pin, wdt, sleep, clear, load
  ccsr_top i_ccsr_top (.MCLK_IN(clk), .ARST_N_IN(rst_n),
    .CORE_OP_VALID_IN(op_v), .CORE_OP_IN(op), .CORE_A_IN(a),
    .CORE_W_IN(cw), .CORE_BIT_IN(bsel), .CORE_DEST_F_IN(dest),
    .CORE_ADDR_IN(addr), .CORE_RD_IN(rd), .CORE_RADDR_IN(raddr),
    .MASTER_RESET_PIN_IN(ev[0]), .WDT_RESET_IN(ev[1]), .SLEEP_IN(ev[2]),
    .WDT_CLEAR_IN(ev[3]), .PC_LOAD_IN(ev[4]), .STATUS_OUT(status),
    .RESULT_OUT(result), .CORE_RDATA_OUT(rdata_c), .PC_UPPER_OUT(pcu),
    .S_AXI_AWADDR_IN(awaddr), .S_AXI_AWVALID_IN(awv),
    .S_AXI_AWREADY_OUT(awrdy), .S_AXI_WDATA_IN(wdata),
    .S_AXI_WSTRB_IN(4'hF), .S_AXI_WVALID_IN(wv), .S_AXI_WREADY_OUT(wrdy),
    .S_AXI_BRESP_OUT(bresp), .S_AXI_BVALID_OUT(bvalid),
    .S_AXI_BREADY_IN(bready), .S_AXI_ARADDR_IN(araddr),
    .S_AXI_ARVALID_IN(arv), .S_AXI_ARREADY_OUT(arrdy),
    .S_AXI_RDATA_OUT(rdata), .S_AXI_RRESP_OUT(rresp),
    .S_AXI_RVALID_OUT(rvalid),
    .S_AXI_RREADY_IN(rready));

  // Clock generation
  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end

  // Verdict and end of run
  task automatic results();
    $display("checks %0d mismatches %0d", samples_checked, fails);
    if (fails == 0 && samples_checked > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // Compare and count
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    samples_checked++;
    if (got !== exp) begin
      $display("mismatch t=%0t got=%h exp=%h", $time, got, exp);
      fails++;
    end
  endtask

  // One core operation, destination taken from dest
  task automatic core(input logic [3:0] o, input logic [7:0] av,
                      input logic [7:0] wv_, input logic [2:0] b,
                      input logic [8:0] ad);
    @(posedge clk);
    op_v <= 1'b1;
    op <= o;
    a <= av;
    cw <= wv_;
    bsel <= b;
    addr <= ad;
    @(posedge clk);
    op_v <= 1'b0;
    #1;
  endtask

  // Event pulse of one cycle
  task automatic evt(input int i);
    @(posedge clk);
    ev[i] <= 1'b1;
    @(posedge clk);
    ev[i] <= 1'b0;
    #1;
  endtask

  // Core-side read with compare
  task automatic cread(input logic [8:0] ra, input logic [7:0] exp);
    @(posedge clk);
    rd <= 1'b1;
    raddr <= ra;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    chk({24'h000000, rdata_c}, {24'h000000, exp});
  endtask

  // AXI4-Lite write, address and data offered together
  task automatic axi_write(input logic [11:0] ad, input logic [31:0] d);
    int n;
    @(posedge clk);
    awaddr <= ad;
    wdata <= d;
    awv <= 1'b1;
    wv <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (awv && awrdy) awv <= 1'b0;
      if (wv && wrdy) wv <= 1'b0;
      if (bvalid) break;
    end
    bready <= 1'b0;
    if (n == 50) begin
      fails++;
      results();
    end
    chk({30'h0, bresp}, {30'h0, AXI_RESP_OKAY});
    #1;
  endtask

  // AXI4-Lite read with compare
  task automatic axi_read(input logic [11:0] ad, input logic [31:0] exp);
    int n;
    @(posedge clk);
    araddr <= ad;
    arv <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 50; n++) begin
      @(posedge clk);
      if (arv && arrdy) arv <= 1'b0;
      if (rvalid) break;
    end
    rready <= 1'b0;
    if (n == 50) begin
      fails++;
      results();
    end
    chk(rdata, exp);
    chk({30'h0, rresp}, {30'h0, AXI_RESP_OKAY});
    #1;
  endtask

  // Main sequence
  initial begin
    {rst_n, op_v, rd, awv, wv, bready, arv, rready} = 8'h00;
    {op, a, cw, bsel, addr, raddr, ev} = '0;
    {awaddr, araddr, wdata} = '0;
    dest = 1'b1;
    fails = 0;
    samples_checked = 0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    #1;
    chk(status, STATUS_POR);
    chk(pcu, 32'h00000000);
    axi_read(AXI_STATUS, 32'h00000018);
    axi_read(12'h008, 32'h00000000);
    axi_write(AXI_STATUS, 32'h0000003F);
    chk(status, 32'h0000003F);
    axi_write(AXI_STATUS, 32'h00000000);
    chk(status, 32'h00000018);
    axi_write(AXI_STATUS, 32'h00000027);
    axi_write(12'h00C, 32'h00000000);
    chk(status, 32'h0000003F);
    core(OP_CLEAR, 8'h55, 8'h00, 3'h0, 9'h083);
    chk(status, 32'h0000001F);
    core(OP_STORE, 8'h00, 8'h00, 3'h0, 9'h103);
    chk(status, 32'h00000018);
    core(OP_STORE, 8'h00, 8'h27, 3'h0, 9'h003);
    chk(status, 32'h0000003F);
    core(OP_SUB, 8'h05, 8'h03, 3'h0, 9'h020);
    chk(status, 32'h0000003B);
    chk(result, 32'h00000002);
    core(OP_SUB, 8'h03, 8'h05, 3'h0, 9'h020);
    chk(status, 32'h00000038);
    chk(result, 32'h000000FE);
    core(OP_SUB, 8'h05, 8'h05, 3'h0, 9'h020);
    chk(status, 32'h0000003F);
    core(OP_RRF, 8'h02, 8'h00, 3'h0, 9'h020);
    chk({status, result}, 32'h00003E81);
    core(OP_RLF, 8'h80, 8'h00, 3'h0, 9'h020);
    chk({status, result}, 32'h00003F00);
    // Result kept in the working register leaves status alone
    @(posedge clk);
    dest <= 1'b0;
    core(OP_STORE, 8'h00, 8'h11, 3'h0, 9'h003);
    chk(status, 32'h0000003F);
    chk(result, 32'h00000011);
    @(posedge clk);
    dest <= 1'b1;
    core(OP_ADD, 8'h00, 8'hE1, 3'h0, 9'h003);
    chk(status, 32'h0000003B);
    chk(result, 32'h00000020);
    evt(1);
    chk(status, 32'h0000000B);
    evt(2);
    chk(status, 32'h00000013);
    evt(3);
    chk(status, 32'h0000001B);
    cread(9'h183, 8'h1B);
    axi_write(AXI_PC_HOLD, 32'h000000FF);
    axi_read(AXI_PC_HOLD, 32'h0000001F);
    cread(9'h10A, 8'h1F);
    cread(9'h020, 8'h00);
    evt(4);
    chk(pcu, 32'h0000001F);
    axi_write(AXI_STATUS, 32'h00000020);
    chk(status, 32'h00000038);
    evt(0);
    chk(status, 32'h00000018);
    cread(9'h00A, 8'h00);
    evt(4);
    chk(pcu, 32'h00000000);
    core(OP_BSET, 8'h00, 8'h00, 3'h0, 9'h003);
    core(OP_BCLR, 8'h00, 8'h00, 3'h4, 9'h083);
    chk(status, 32'h00000019);
    results();
  end
endmodule
